/* cmd_mode_pkg.sv */
// Constants and types for the command-mode control block
// Operation
// [RULE1] Idle after inactivity span, 100 ms units
// [RULE2] Exit command leaves command mode immediately
// [RULE3] Guard silence before and after sequence
// [RULE4] Enter only on silence, sequence, silence
// [RULE5] Programmable readable sequence character, reset plus
// [RULE6] Read-only 16-bit firmware version word
// [RULE7] Read-only 16-bit hardware version word
// [RULE8] Join status: zero joined, all ones scanning
// [RULE9] Scan outcome codes 0x21 to 0x27
// [RULE10] Coordinator and leave codes 0x2A-0x2C
// [RULE11] Join and security fault codes 0xAB-0xAF
// [RULE12] Host polls join status until zero
// [RULE13] Sequence is three consecutive sequence characters
package cmd_mode_pkg;
    localparam int          CLK_HZ          = 125000000;   // Core clock rate
    localparam int          MS_PER_TICK     = 1;           // Fine tick unit in ms
    localparam int          MS_TICK_CYCLES  = CLK_HZ / 1000 * MS_PER_TICK; // Cycles per 1 ms
    localparam int          SLOW_MS         = 100;         // Coarse tick unit in ms
    localparam logic [15:0] TIMEOUT_RESET   = 16'h0064;    // Inactivity span after reset
    localparam logic [15:0] TIMEOUT_MIN     = 16'h0002;    // Least accepted span
    localparam logic [15:0] TIMEOUT_MAX     = 16'h028F;    // Largest accepted span
    localparam logic [15:0] GUARD_RESET     = 16'h03E8;    // Guard interval after reset
    localparam logic [15:0] GUARD_MIN       = 16'h0001;    // Least accepted guard
    localparam logic [15:0] GUARD_MAX       = 16'h0CE4;    // Largest accepted guard
    localparam logic [7:0]  SEQ_CHAR_RESET  = 8'h2B;       // Plus sign
    localparam int          SEQ_COUNT       = 3;           // Copies of sequence char
    // Register selects on the parameter port
    localparam logic [2:0]  SEL_FW_VERSION  = 3'h0;
    localparam logic [2:0]  SEL_HW_VERSION  = 3'h1;
    localparam logic [2:0]  SEL_JOIN_STATUS = 3'h2;
    localparam logic [2:0]  SEL_TIMEOUT     = 3'h3;
    localparam logic [2:0]  SEL_GUARD       = 3'h4;
    localparam logic [2:0]  SEL_SEQ_CHAR    = 3'h5;
    // Join status codes
    localparam logic [7:0]  JOIN_OK           = 8'h00;
    localparam logic [7:0]  JOIN_NO_NET       = 8'h21;
    localparam logic [7:0]  JOIN_NO_VALID     = 8'h22;
    localparam logic [7:0]  JOIN_NOT_PERMIT   = 8'h23;
    localparam logic [7:0]  JOIN_NO_BEACON    = 8'h24;
    localparam logic [7:0]  JOIN_UNEXPECTED   = 8'h25;
    localparam logic [7:0]  JOIN_FAILED       = 8'h27;
    localparam logic [7:0]  JOIN_COORD_FAIL   = 8'h2A;
    localparam logic [7:0]  JOIN_COORD_CHECK  = 8'h2B;
    localparam logic [7:0]  JOIN_LEAVE_FAIL   = 8'h2C;
    localparam logic [7:0]  JOIN_NO_RESPONSE  = 8'hAB;
    localparam logic [7:0]  JOIN_KEY_UNSECURE = 8'hAC;
    localparam logic [7:0]  JOIN_NO_KEY       = 8'hAD;
    localparam logic [7:0]  JOIN_BAD_LINK_KEY = 8'hAF;
    localparam logic [7:0]  JOIN_SCANNING     = 8'hFF;
    // Sequence detector states
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,  // Data mode, watching pre-guard silence
        ST_ARMED   = 3'b001,  // Pre-guard met, waiting for first char
        ST_COLLECT = 3'b010,  // Collecting sequence characters
        ST_POST    = 3'b011,  // Waiting post-guard silence
        ST_COMMAND = 3'b100   // Command mode
    } mode_e;
endpackage : cmd_mode_pkg

/* cmd_mode_ctrl.sv */
// Command-mode detector, timeout and diagnostic word store
`timescale 1ns/1ps
module cmd_mode_ctrl
    import cmd_mode_pkg::*;
#(
    parameter int          MS_CYCLES = cmd_mode_pkg::MS_TICK_CYCLES, // Cycles per ms tick
    parameter logic [15:0] FW_VERSION = 16'h0000, // Arbitrary value
    parameter logic [15:0] HW_VERSION = 16'h0000  // Arbitrary value
) (
    input  wire logic        clock,        // Core clock
    input  wire logic        sys_rst,      // Synchronous reset
    input  wire logic        rx_valid,     // Received serial character strobe
    input  wire logic [7:0]  rx_data,      // Received character
    input  wire logic        cmd_valid,    // Valid command parsed in command mode
    input  wire logic        exit_cmd,     // Explicit exit command strobe
    input  wire logic        reg_wr,       // Parameter write strobe
    input  wire logic [2:0]  reg_sel,      // Parameter select
    input  wire logic [15:0] reg_wdata,    // Parameter write data
    input  wire logic        join_wr,      // Network side updates join status
    input  wire logic [7:0]  join_code,    // New join status code
    output logic [15:0]      reg_rdata,    // Registered read data
    output logic             command_mode, // High while in command mode
    output logic             enter_pulse,  // One cycle on entering command mode
    output logic             exit_pulse    // One cycle on leaving command mode
);
    import cmd_mode_pkg::*;

    localparam int TW = $clog2(MS_CYCLES + 1);

    mode_e       state_q;       // Detector state
    logic [15:0] timeout_q;     // Inactivity span, 100 ms units
    logic [15:0] guard_q;       // Guard interval, 1 ms units
    logic [7:0]  seq_char_q;    // Sequence character
    logic [7:0]  join_q;        // Join status code
    logic [TW-1:0] div_q;       // Millisecond divider
    logic        ms_tick;       // One-cycle 1 ms enable
    logic [6:0]  slow_q;        // Counts ms to 100
    logic        slow_tick;     // One-cycle 100 ms enable
    logic [15:0] quiet_ms_q;    // ms of silence since last char
    logic [15:0] idle_q;        // 100 ms units with no valid command
    logic [1:0]  seq_cnt_q;     // Sequence chars seen
    logic        guard_met;     // Silence reached guard interval
    logic        leave;         // Leave command mode this cycle
    logic        entering;      // Post-guard silence reached in ST_POST

    // Millisecond and 100 ms enable pulses from one divider chain
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            div_q  <= '0;
            slow_q <= '0;
        end else if (div_q == TW'(MS_CYCLES - 1)) begin
            // Wrap the ms divider and step the 100 ms count
            div_q  <= '0;
            slow_q <= (slow_q == 7'(SLOW_MS - 1)) ? 7'h00 : slow_q + 7'h01;
        end else begin
            div_q <= div_q + TW'(1);
        end
    end
    assign ms_tick   = (div_q == TW'(MS_CYCLES - 1));
    assign slow_tick = ms_tick && (slow_q == 7'(SLOW_MS - 1));

    // Silence timer, restarted by every received character
    always_ff @(posedge clock) begin
        if (sys_rst || rx_valid) begin
            quiet_ms_q <= '0;                                    // [RULE3]
        end else if (ms_tick && !guard_met) begin
            // Count stops once guard is met, so it never wraps
            quiet_ms_q <= quiet_ms_q + 16'h0001;
        end
    end
    // Strict compare: the ms divider free-runs, so the first tick after a
    // character may come at once; one extra tick keeps silence >= guard
    assign guard_met = (quiet_ms_q > guard_q);                   // [RULE3]

    // Exit on explicit command or expired inactivity span
    // Strict compare: the first 100 ms tick after a command may come at
    // once, so one extra tick keeps the span from ending early
    assign leave = (state_q == ST_COMMAND) &&
                   (exit_cmd || (idle_q > timeout_q));           // [RULE1] [RULE2]

    // Entry condition for the mode outputs; the ST_POST state update tests the same terms itself
    assign entering = (state_q == ST_POST) && guard_met && !rx_valid; // [RULE4]

    // Sequence detector and mode state
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            // Data mode after reset
            state_q   <= ST_IDLE;
            seq_cnt_q <= '0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    // Pre-guard silence arms detection
                    if (guard_met && !rx_valid) begin
                        state_q <= ST_ARMED;                     // [RULE4]
                    end
                end
                ST_ARMED: begin
                    // First sequence character starts collection
                    if (rx_valid) begin
                        if (rx_data == seq_char_q) begin
                            state_q   <= ST_COLLECT;             // [RULE13]
                            seq_cnt_q <= 2'h1;
                        end else begin
                            state_q <= ST_IDLE;                  // [RULE4]
                        end
                    end
                end
                ST_COLLECT: begin
                    // Wrong char aborts; the last copy waits for post-guard
                    if (rx_valid) begin
                        if (rx_data != seq_char_q) begin
                            state_q <= ST_IDLE;                  // [RULE13]
                        end else if (seq_cnt_q == 2'(SEQ_COUNT - 1)) begin
                            state_q <= ST_POST;                  // [RULE13]
                        end else begin
                            seq_cnt_q <= seq_cnt_q + 2'h1;
                        end
                    end else if (guard_met) begin
                        // Gap too long: re-arm and count afresh
                        state_q <= ST_ARMED;                     // [RULE13]
                    end
                end
                ST_POST: begin
                    // Any char before post-guard aborts entry
                    if (rx_valid) begin
                        state_q <= ST_IDLE;                      // [RULE3]
                    end else if (guard_met) begin
                        state_q <= ST_COMMAND;                   // [RULE4]
                    end
                end
                ST_COMMAND: begin
                    // Leave on exit command or inactivity
                    if (leave) begin
                        state_q <= ST_IDLE;                      // [RULE1] [RULE2]
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Inactivity counter in 100 ms units
    always_ff @(posedge clock) begin
        if (sys_rst || state_q != ST_COMMAND || cmd_valid) begin
            idle_q <= '0;                                        // [RULE1]
        end else if (slow_tick && idle_q != 16'hFFFF) begin
            idle_q <= idle_q + 16'h0001;                         // [RULE1]
        end
    end

    // Writable parameters, clamped into their legal ranges
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            timeout_q  <= TIMEOUT_RESET;                         // [RULE1]
            guard_q    <= GUARD_RESET;                           // [RULE3]
            seq_char_q <= SEQ_CHAR_RESET;                        // [RULE5]
        end else if (reg_wr) begin
            unique case (reg_sel)
                SEL_TIMEOUT: begin
                    // Span held inside its legal range
                    timeout_q <= (reg_wdata < TIMEOUT_MIN) ? TIMEOUT_MIN :
                                 (reg_wdata > TIMEOUT_MAX) ? TIMEOUT_MAX : reg_wdata;
                end
                SEL_GUARD: begin
                    // Guard held inside its legal range
                    guard_q <= (reg_wdata < GUARD_MIN) ? GUARD_MIN :
                               (reg_wdata > GUARD_MAX) ? GUARD_MAX : reg_wdata;
                end
                SEL_SEQ_CHAR: begin
                    // Any 8-bit value accepted
                    seq_char_q <= reg_wdata[7:0];                // [RULE5]
                end
                default: begin
                    // Read-only or unmapped selects ignore writes
                end
            endcase
        end
    end

    // Join status held from network side; scanning after reset
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            join_q <= JOIN_SCANNING;                             // [RULE8]
        end else if (join_wr) begin
            // Only the network side changes the code
            join_q <= join_code;                                 // [RULE8] [RULE9] [RULE10] [RULE11]
        end
    end

    // Registered read mux
    // Eight-bit words read back in the low byte, upper byte zero
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else begin
            unique case (reg_sel)
                SEL_FW_VERSION:  reg_rdata <= FW_VERSION;        // [RULE6]
                SEL_HW_VERSION:  reg_rdata <= HW_VERSION;        // [RULE7]
                SEL_JOIN_STATUS: reg_rdata <= {8'h00, join_q};   // [RULE8]
                SEL_TIMEOUT:     reg_rdata <= timeout_q;
                SEL_GUARD:       reg_rdata <= guard_q;
                SEL_SEQ_CHAR:    reg_rdata <= {8'h00, seq_char_q}; // [RULE5]
                default:         reg_rdata <= 16'h0000;
            endcase
        end
    end

    // Mode outputs and entry/exit pulses
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            command_mode <= 1'b0;
            enter_pulse  <= 1'b0;
            exit_pulse   <= 1'b0;
        end else begin
            // Pulses mark the rise and fall of the mode level
            enter_pulse  <= entering;                            // [RULE4]
            exit_pulse   <= leave;                               // [RULE1] [RULE2]
            command_mode <= entering ||
                            ((state_q == ST_COMMAND) && !leave);
        end
    end
endmodule : cmd_mode_ctrl

/* cmd_mode_checker.sv */
// Concurrent checks on the command-mode control block ports
`timescale 1ns/1ps
module cmd_mode_checker
    import cmd_mode_pkg::*;
#(
    parameter logic [15:0] FW_VERSION = 16'h0000, // Arbitrary value
    parameter logic [15:0] HW_VERSION = 16'h0000  // Arbitrary value
) (
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        rx_valid,
    input wire logic [7:0]  rx_data,
    input wire logic        cmd_valid,
    input wire logic        exit_cmd,
    input wire logic        reg_wr,
    input wire logic [2:0]  reg_sel,
    input wire logic [15:0] reg_wdata,
    input wire logic        join_wr,
    input wire logic [7:0]  join_code,
    input wire logic [15:0] reg_rdata,
    input wire logic        command_mode,
    input wire logic        enter_pulse,
    input wire logic        exit_pulse
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // Entry pulse only on the rise of command mode, one cycle long
    property p_enter_edge; enter_pulse |-> command_mode && !$past(command_mode); endproperty
    a_enter_edge: assert property (p_enter_edge) else $error("enter pulse without mode rise");
    property p_enter_once; enter_pulse |=> !enter_pulse && (command_mode || exit_pulse); endproperty
    a_enter_once: assert property (p_enter_once) else $error("enter pulse too long");
    // Exit command leaves at once
    property p_exit_now; command_mode && exit_cmd |=> exit_pulse && !command_mode; endproperty
    a_exit_now: assert property (p_exit_now) else $error("exit command not taken");
    property p_exit_edge; exit_pulse |-> !command_mode && $past(command_mode); endproperty
    a_exit_edge: assert property (p_exit_edge) else $error("exit pulse without mode fall");
    property p_exit_once; exit_pulse |=> !exit_pulse; endproperty
    a_exit_once: assert property (p_exit_once) else $error("exit pulse too long");
    // Read-only words and byte placement
    property p_fw; !$past(sys_rst) && $past(reg_sel) == SEL_FW_VERSION |-> reg_rdata == FW_VERSION; endproperty
    a_fw: assert property (p_fw) else $error("firmware word wrong");
    property p_hw; !$past(sys_rst) && $past(reg_sel) == SEL_HW_VERSION |-> reg_rdata == HW_VERSION; endproperty
    a_hw: assert property (p_hw) else $error("hardware word wrong");
    property p_seq_hi; !$past(sys_rst) && $past(reg_sel) == SEL_SEQ_CHAR |-> reg_rdata[15:8] == 8'h00; endproperty
    a_seq_hi: assert property (p_seq_hi) else $error("sequence char upper byte set");
    property p_join;
        join_wr && reg_sel == SEL_JOIN_STATUS ##1 !join_wr && reg_sel == SEL_JOIN_STATUS
            |=> reg_rdata == {8'h00, $past(join_code, 2)};
    endproperty
    a_join: assert property (p_join) else $error("join status not loaded");
endmodule : cmd_mode_checker

/* serial_host.sv */
// Host-side serial model that sends characters to the block
`timescale 1ns/1ps
module serial_host #(
    parameter int MS = 4 // Cycles per ms tick
) (
    input  wire logic       clock,    // Core clock
    output logic            rx_valid, // Character strobe
    output logic [7:0]      rx_data   // Character
);
    // Idle line at time zero
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'hA5;
    end
    // One character; data then changes so no stale value lingers
    task automatic send(input logic [7:0] c);
        @(posedge clock);
        rx_valid <= 1'b1;
        rx_data  <= c;
        @(posedge clock);
        rx_valid <= 1'b0;
        rx_data  <= ~c;
    endtask : send
    // Line silence for a number of ms ticks
    task automatic quiet(input int ms);
        repeat (ms * MS) @(posedge clock);
    endtask : quiet
endmodule : serial_host

/* tb_top.sv */
// Self-checking bench for the command-mode control block
`timescale 1ns/1ps
module tb_top;
    import cmd_mode_pkg::*;
    localparam int          MS = 4;         // Shortened ms tick
    localparam logic [15:0] FW = 16'h5A13;  // Arbitrary value
    localparam logic [15:0] HW = 16'h3C07;  // Arbitrary value
    logic        clock = 0, sys_rst = 1, cmd_valid = 0, exit_cmd = 0, reg_wr = 0, join_wr = 0;
    logic [2:0]  reg_sel = 0;
    logic [15:0] reg_wdata = 0, reg_rdata;
    logic [7:0]  join_code = 0, rx_data;
    logic        rx_valid, command_mode, enter_pulse, exit_pulse;
    int          mismatches = 0, n_checks = 0, cyc = 0, n_enter = 0;
    logic [15:0] rst_vals [7] = '{FW, HW, 16'h00FF, 16'h0064, 16'h03E8, 16'h002B, 16'h0000};
    logic [7:0]  codes [15] = '{8'hFF, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h27, 8'h2A, 8'h2B,
                                8'h2C, 8'hAB, 8'hAC, 8'hAD, 8'hAF, 8'h00};
    cmd_mode_ctrl #(.MS_CYCLES(MS), .FW_VERSION(FW), .HW_VERSION(HW)) u_cmd_mode_ctrl (
        .clock(clock), .sys_rst(sys_rst), .rx_valid(rx_valid), .rx_data(rx_data), .cmd_valid(cmd_valid),
        .exit_cmd(exit_cmd), .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .join_wr(join_wr),
        .join_code(join_code), .reg_rdata(reg_rdata), .command_mode(command_mode),
        .enter_pulse(enter_pulse), .exit_pulse(exit_pulse));
    serial_host #(.MS(MS)) u_serial_host (.clock(clock), .rx_valid(rx_valid), .rx_data(rx_data));
    always #4 clock = ~clock;
    // Count entry pulses; watchdog on run length
    always @(posedge clock) begin
        if (enter_pulse === 1'b1) n_enter <= n_enter + 1;
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic rd(logic [2:0] sel, logic [15:0] exp, string what);
        @(posedge clock);
        reg_sel <= sel;
        repeat (2) @(posedge clock);
        #1 chk(what, exp, reg_rdata);
    endtask : rd
    task automatic wr(logic [2:0] sel, logic [15:0] d);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_sel   <= sel;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask : wr
    // Guard silence, optional lead char, three chars, guard window, then entry check
    task automatic esc(logic [7:0] lead, a, b, c, logic exp, string what);
        int base;
        base = n_enter;
        u_serial_host.quiet(4);
        if (lead != 8'h00) u_serial_host.send(lead);
        u_serial_host.send(a);
        u_serial_host.send(b);
        u_serial_host.send(c);
        repeat (24) @(posedge clock);
        chk(what, {15'h0, exp}, 16'(n_enter - base));
        chk("command_mode", {15'h0, exp}, {15'h0, command_mode});
    endtask : esc
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        for (int i = 0; i < 7; i++) rd(i[2:0], rst_vals[i], "reset value");
        wr(SEL_FW_VERSION, 16'h1111);
        rd(SEL_FW_VERSION, FW, "firmware read-only");
        wr(SEL_TIMEOUT, 16'h0000);
        rd(SEL_TIMEOUT, 16'h0002, "timeout clamp");
        wr(SEL_GUARD, 16'hFFFF);
        rd(SEL_GUARD, 16'h0CE4, "guard clamp");
        wr(SEL_GUARD, 16'h0002);
        esc(8'h00, 8'h2B, 8'h2B, 8'h2B, 1'b1, "entry");
        @(posedge clock);
        exit_cmd <= 1'b1;
        @(posedge clock);
        exit_cmd <= 1'b0;
        #1 chk("exit now", 16'h0002, {14'h0, exit_pulse, command_mode});
        esc(8'h00, 8'h2B, 8'h41, 8'h2B, 1'b0, "broken sequence");
        esc(8'h55, 8'h2B, 8'h2B, 8'h2B, 1'b0, "no pre-guard");
        wr(SEL_SEQ_CHAR, 16'h0041);
        rd(SEL_SEQ_CHAR, 16'h0041, "sequence char");
        esc(8'h00, 8'h41, 8'h41, 8'h41, 1'b1, "new char entry");
        repeat (300) @(posedge clock);
        cmd_valid <= 1'b1;
        @(posedge clock);
        cmd_valid <= 1'b0;
        repeat (780) @(posedge clock);
        #1 chk("still in mode", 16'h0001, {15'h0, command_mode});
        for (int i = 0; i < 500 && command_mode === 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        chk("timeout exit", 16'h0000, {15'h0, command_mode});
        foreach (codes[i]) begin
            @(posedge clock);
            reg_sel   <= SEL_JOIN_STATUS;
            join_wr   <= 1'b1;
            join_code <= codes[i];
            @(posedge clock);
            join_wr   <= 1'b0;
            rd(SEL_JOIN_STATUS, {8'h00, codes[i]}, "join status");
        end
        give_verdict();
    end
endmodule : tb_top
bind cmd_mode_ctrl cmd_mode_checker #(.FW_VERSION(FW_VERSION), .HW_VERSION(HW_VERSION)) u_chk (
    .clock(clock), .sys_rst(sys_rst), .rx_valid(rx_valid), .rx_data(rx_data), .cmd_valid(cmd_valid),
    .exit_cmd(exit_cmd), .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .join_wr(join_wr),
    .join_code(join_code), .reg_rdata(reg_rdata), .command_mode(command_mode),
    .enter_pulse(enter_pulse), .exit_pulse(exit_pulse));
